// file: verilog/exec_defines.svh
// constants for the jump / increment execution block
// assumes a 12-bit instruction word and an 8-bit data path
`ifndef EXEC_DEFINES_SVH
`define EXEC_DEFINES_SVH
`define JMP_OP 3'h5
`define INC_OP 6'h0A
`define INCSZ_OP 6'h0F
`define PC_W 11
`define DATA_W 8
`define FADDR_W 5
`define ONE_8 8'h01
`define ZERO_8 8'h00
`define ZERO_11 11'h000
`define FF_8 8'hFF
`define INSN_W 12
`define JMP_LSB 9
`define INC_LSB 6
`define DEST_BIT 5
`define TARGET_W 9
`endif

// file: verilog/exec_pkg.sv
// types for the jump / increment execution block
// includes exec_defines.svh itself for the widths
`include "exec_defines.svh"
package exec_pkg;
	typedef struct packed {
		logic we;
		logic [`FADDR_W-1:0] addr;
		logic [`DATA_W-1:0] data;
	} file_wr_type;
	typedef enum logic [1:0] {OP_NONE, OP_JMP, OP_INC, OP_INCSZ} op_type;
endpackage

// file: verilog/insn_decode.sv
// decoder for the jump and the two increments
// assumes a plain 12-bit word, already qualified by the caller
`timescale 1ns/1ps
`include "exec_defines.svh"
module insn_decode (
	// instruction
	input wire logic [11:0] insn_in,
	// decoded class
	output exec_pkg::op_type op_out
);
	wire is_jmp = insn_in[`INSN_W-1:`JMP_LSB] == `JMP_OP;
	wire is_inc = insn_in[`INSN_W-1:`INC_LSB] == `INC_OP;
	wire is_incsz = insn_in[`INSN_W-1:`INC_LSB] == `INCSZ_OP;
	assign op_out = is_jmp ? exec_pkg::OP_JMP :
		is_inc ? exec_pkg::OP_INC :
		is_incsz ? exec_pkg::OP_INCSZ : exec_pkg::OP_NONE;
endmodule

// file: verilog/branch_and_increment_exec.sv
// executes jump_absolute, increment_register and increment_skip_zero
// assumes fetch gives one word per cycle with insn_valid_in, file data read
// combinationally at insn_in[4:0], and status bits 6:5 from outside
`timescale 1ns/1ps
`include "exec_defines.svh"
module branch_and_increment_exec (
	// clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// fetched instruction
	input wire logic [11:0] insn_in,
	input wire logic insn_valid_in,
	// operands
	input wire logic [`DATA_W-1:0] file_rd_in,
	input wire logic [1:0] status_page_in,
	// results
	output logic [`PC_W-1:0] pc_out,
	output logic pc_load_out,
	output logic flush_out,
	output logic [`DATA_W-1:0] acc_out,
	output logic acc_we_out,
	output exec_pkg::file_wr_type file_wr_out,
	output logic zero_out,
	output logic zero_we_out
);
	exec_pkg::op_type op;
	logic flush_q;
	exec_pkg::file_wr_type file_wr_d;
	insn_decode i_insn_decode (
		.insn_in(insn_in),
		.op_out(op)
	);
	// the word after a jump or a skip is already fetched and must die here
	wire live = insn_valid_in & ~flush_q;
	wire do_jmp = live & (op == exec_pkg::OP_JMP);
	wire do_inc = live & (op == exec_pkg::OP_INC);
	wire do_incsz = live & (op == exec_pkg::OP_INCSZ);
	wire do_any_inc = do_inc | do_incsz;
	// operand fields of the word
	wire to_file = insn_in[`DEST_BIT];
	wire [`FADDR_W-1:0] file_addr = insn_in[`FADDR_W-1:0];
	wire [`DATA_W-1:0] sum = file_rd_in + `ONE_8;
	wire sum_zero = sum == `ZERO_8;
	wire [`PC_W-1:0] jmp_target = {status_page_in, insn_in[`TARGET_W-1:0]};
	wire skip = do_incsz & sum_zero;
	// unconditional, second cycle is a flush
	wire pc_load_d = do_jmp;
	wire flush_pulse_d = do_jmp | skip;
	// a pending flush waits out idle cycles; dropping it early would let the
	// discarded word run whenever fetch stalls right after a jump or skip
	wire flush_d = flush_pulse_d | (flush_q & ~insn_valid_in);
	// same routing for the skip form
	wire acc_we_d = do_any_inc & ~to_file;
	wire file_we_d = do_any_inc & to_file;
	assign file_wr_d = {file_we_d, file_addr, sum};
	// only the plain increment writes zero
	wire zero_we_d = do_inc;
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			flush_q <= 1'b0;
		end else begin
			flush_q <= flush_d;
		end
	end
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pc_out <= `ZERO_11;
			pc_load_out <= 1'b0;
		end else begin
			pc_out <= jmp_target;
			pc_load_out <= pc_load_d;
		end
	end
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			flush_out <= 1'b0;
		end else begin
			flush_out <= flush_pulse_d;
		end
	end
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			acc_out <= `ZERO_8;
			acc_we_out <= 1'b0;
		end else begin
			acc_out <= sum;
			acc_we_out <= acc_we_d;
		end
	end
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			file_wr_out <= '0;
		end else begin
			file_wr_out <= file_wr_d;
		end
	end
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			zero_out <= 1'b0;
			zero_we_out <= 1'b0;
		end else begin
			zero_out <= sum_zero;
			zero_we_out <= zero_we_d;
		end
	end
	property p_jmp_load;
		@(posedge clk_in) disable iff (!rstn_in)
		do_jmp |=> pc_load_out && pc_out == $past(jmp_target) && flush_out;
	endproperty
	a_jmp_load: assert property (p_jmp_load) else $error("jump not loaded");
	property p_page;
		@(posedge clk_in) disable iff (!rstn_in)
		do_jmp |=> pc_out[`PC_W-1:`TARGET_W] == $past(status_page_in);
	endproperty
	a_page: assert property (p_page) else $error("page bits wrong");
	property p_jmp_noflag;
		@(posedge clk_in) disable iff (!rstn_in)
		do_jmp |=> !zero_we_out ##1 !pc_load_out && !acc_we_out && !file_wr_out.we;
	endproperty
	a_jmp_noflag: assert property (p_jmp_noflag) else $error("jump took wrong cycles");
	property p_inc;
		@(posedge clk_in) disable iff (!rstn_in)
		do_inc |=> zero_we_out && zero_out == (acc_out == `ZERO_8) && (acc_we_out != file_wr_out.we);
	endproperty
	a_inc: assert property (p_inc) else $error("increment wrong");
	property p_incsz;
		@(posedge clk_in) disable iff (!rstn_in)
		do_incsz |=> !zero_we_out && (acc_we_out == !$past(to_file));
	endproperty
	a_incsz: assert property (p_incsz) else $error("skip increment wrong");
	property p_skip;
		@(posedge clk_in) disable iff (!rstn_in)
		skip |=> flush_out ##1 !acc_we_out && !file_wr_out.we && !pc_load_out;
	endproperty
	a_skip: assert property (p_skip) else $error("skip not taken");
	property p_wrap;
		@(posedge clk_in) disable iff (!rstn_in)
		do_any_inc && file_rd_in == `FF_8 |=> acc_out == `ZERO_8 && zero_out;
	endproperty
	a_wrap: assert property (p_wrap) else $error("no wrap");
	property p_flush_hold;
		@(posedge clk_in) disable iff (!rstn_in)
		flush_q && !insn_valid_in |=> flush_q;
	endproperty
	a_flush_hold: assert property (p_flush_hold) else $error("pending flush lost");
	property p_flush_kill;
		@(posedge clk_in) disable iff (!rstn_in)
		flush_q && insn_valid_in |=> !pc_load_out && !acc_we_out && !file_wr_out.we
			&& !zero_we_out && !flush_out;
	endproperty
	a_flush_kill: assert property (p_flush_kill) else $error("flushed word acted");
	property p_flush_once;
		@(posedge clk_in) disable iff (!rstn_in)
		flush_q && insn_valid_in |=> !flush_q;
	endproperty
	a_flush_once: assert property (p_flush_once) else $error("flush kept too long");
	property p_jmp_low;
		@(posedge clk_in) disable iff (!rstn_in)
		do_jmp |=> pc_out[`TARGET_W-1:0] == $past(insn_in[`TARGET_W-1:0]);
	endproperty
	a_jmp_low: assert property (p_jmp_low) else $error("jump low bits wrong");
	property p_jmp_pulse;
		@(posedge clk_in) disable iff (!rstn_in)
		pc_load_out |=> !pc_load_out;
	endproperty
	a_jmp_pulse: assert property (p_jmp_pulse) else $error("load held over");
	property p_jmp_nowrite;
		@(posedge clk_in) disable iff (!rstn_in)
		do_jmp |=> !acc_we_out && !file_wr_out.we;
	endproperty
	a_jmp_nowrite: assert property (p_jmp_nowrite) else $error("jump wrote data");
	property p_inc_sum;
		@(posedge clk_in) disable iff (!rstn_in)
		do_any_inc |=> acc_out == $past(file_rd_in) + `ONE_8;
	endproperty
	a_inc_sum: assert property (p_inc_sum) else $error("sum wrong");
	property p_inc_dest;
		@(posedge clk_in) disable iff (!rstn_in)
		do_inc |=> file_wr_out.we == $past(insn_in[`DEST_BIT]);
	endproperty
	a_inc_dest: assert property (p_inc_dest) else $error("wrong destination");
	property p_inc_noskip;
		@(posedge clk_in) disable iff (!rstn_in)
		do_inc |=> !flush_out;
	endproperty
	a_inc_noskip: assert property (p_inc_noskip) else $error("plain increment skipped");
	property p_file_word;
		@(posedge clk_in) disable iff (!rstn_in)
		do_incsz && to_file |=> file_wr_out.we && file_wr_out.data == acc_out
			&& file_wr_out.addr == $past(insn_in[`FADDR_W-1:0]);
	endproperty
	a_file_word: assert property (p_file_word) else $error("file write wrong");
	property p_incsz_noskip;
		@(posedge clk_in) disable iff (!rstn_in)
		do_incsz && !sum_zero |=> !flush_out;
	endproperty
	a_incsz_noskip: assert property (p_incsz_noskip) else $error("skip on nonzero");
	property p_flag_src;
		@(posedge clk_in) disable iff (!rstn_in)
		zero_we_out |-> $past(do_inc);
	endproperty
	a_flag_src: assert property (p_flag_src) else $error("flag written wrongly");
	property p_one_dest;
		@(posedge clk_in) disable iff (!rstn_in)
		acc_we_out |-> !file_wr_out.we;
	endproperty
	a_one_dest: assert property (p_one_dest) else $error("two destinations");
endmodule

// file: tb/branch_and_increment_exec_tb.sv
// bench for the jump / increment execution block
// drives every port itself; file read data and status page come from the bench
`timescale 1ns/1ps
`include "exec_defines.svh"
module branch_and_increment_exec_tb;
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [11:0] insn_in = 12'h000;
	logic insn_valid_in = 1'b0;
	logic [7:0] file_rd_in = 8'h00;
	logic [1:0] status_page_in = 2'h0;
	logic [10:0] pc_out;
	logic [7:0] acc_out;
	logic pc_load_out, flush_out, acc_we_out, zero_out, zero_we_out;
	exec_pkg::file_wr_type file_wr_out;
	wire logic [4:0] stb = {pc_load_out, flush_out, acc_we_out, file_wr_out.we, zero_we_out};
	int num_errors = 0;
	int checked = 0;
	always #20 clk_in = ~clk_in;
	branch_and_increment_exec i_branch_and_increment_exec (.clk_in(clk_in), .rstn_in(rstn_in),
		.insn_in(insn_in), .insn_valid_in(insn_valid_in), .file_rd_in(file_rd_in),
		.status_page_in(status_page_in), .pc_out(pc_out), .pc_load_out(pc_load_out),
		.flush_out(flush_out), .acc_out(acc_out), .acc_we_out(acc_we_out),
		.file_wr_out(file_wr_out), .zero_out(zero_out), .zero_we_out(zero_we_out));
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// outputs are registered, so they are judged just after the edge that took the word
	task issue(input logic [11:0] w, input logic [7:0] rd);
		@(posedge clk_in);
		#1 insn_in = w;
		insn_valid_in = 1'b1;
		file_rd_in = rd;
		@(posedge clk_in);
		#1 insn_valid_in = 1'b0;
	endtask
	task t_jump;
		status_page_in = 2'h2;
		issue(12'hBFF, 8'h00);
		chk(stb, 16'h0018);
		chk(pc_out, 16'h05FF);
		issue(12'h283, 8'h10);
		chk(stb, 16'h0000);
		issue(12'h283, 8'h10);
		chk(acc_out, 16'h0011);
	endtask
	task t_inc;
		issue(12'h283, 8'hFF);
		chk(stb, 16'h0005);
		chk({acc_out, 7'h00, zero_out}, 16'h0001);
		issue(12'h2A4, 8'h41);
		chk(stb, 16'h0003);
		chk({file_wr_out.addr, file_wr_out.data, zero_out}, 16'h0884);
	endtask
	task t_incsz;
		issue(12'h3C7, 8'h05);
		chk(stb, 16'h0004);
		chk(acc_out, 16'h0006);
		issue(12'h3FF, 8'hFF);
		chk(stb, 16'h000A);
		chk({file_wr_out.addr, file_wr_out.data}, 16'h1F00);
		issue(12'hA00, 8'h00);
		chk(stb, 16'h0000);
		issue(12'h000, 8'h00);
		chk(stb, 16'h0000);
	endtask
	task summarize;
		$display("errors=%0d checks=%0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		#20000;
		num_errors++;
		summarize();
	end
	initial begin
		repeat (4) @(posedge clk_in);
		#1 rstn_in = 1'b1;
		chk(stb, 16'h0000);
		t_jump();
		t_inc();
		t_incsz();
		summarize();
	end
endmodule
